// >>> verilog/epc_defs.svh
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH

// ---------------------------------------------------------------
// Core event numbers, lower number is higher priority
// ---------------------------------------------------------------
`define EPC_NUM_EVT 16
`define EPC_EV_EMU 4'h0
`define EPC_EV_RST 4'h1
`define EPC_EV_NMI 4'h2
`define EPC_EV_EXC 4'h3
`define EPC_EV_HWE 4'h5
`define EPC_EV_TMR 4'h6
`define EPC_GP_BASE 4'h7
`define EPC_NUM_GP 9
`define EPC_GP_MAX 4'h8

// ---------------------------------------------------------------
// Bit groups of the 16-bit core vectors
// ---------------------------------------------------------------
`define EPC_NOMASK_BITS 16'h000f
`define EPC_RSVD_BITS 16'h0010
`define EPC_GP_BITS 16'hff80
`define EPC_RST_ONLY 16'h0002
`define EPC_ZERO16 16'h0000
`define EPC_ONE16 16'h0001

`endif

// >>> verilog/epc_pkg.sv
package epc_pkg;

   // Event handed to the pipeline.
   typedef struct packed {
      logic valid;
      logic [3:0] num;
   } epc_take_s;

   // Result of a priority search.
   typedef struct packed {
      logic found;
      logic [3:0] idx;
   } epc_hit_s;

endpackage

// >>> verilog/epc_event_priority_controller.sv
`timescale 1ns/10ps
`include "epc_defs.svh"

module epc_event_priority_controller #(
   parameter int NUM_SRC = 56,
   parameter int ADDR_W = 32
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Peripheral requests and nonmaskable pin
   input wire logic [NUM_SRC-1:0] periph_req_i,
   input wire logic nmi_n_i,
   // Dedicated events from core logic
   input wire logic emu_req_i,
   input wire logic reset_req_i,
   input wire logic watchdog_nmi_i,
   input wire logic exception_i,
   input wire logic hw_error_i,
   input wire logic core_timer_i,
   // Software raise of a general level
   input wire logic sw_raise_i,
   input wire logic [3:0] sw_level_i,
   // Source to level assignment
   input wire logic asg_wr_i,
   input wire logic [$clog2(NUM_SRC)-1:0] asg_src_i,
   input wire logic [3:0] asg_level_i,
   // Masking
   input wire logic [15:0] core_mask_i,
   input wire logic gp_enable_i,
   // Pipeline side
   input wire logic [ADDR_W-1:0] pc_i,
   input wire logic rfe_i,
   input wire logic [3:0] rfe_num_i,
   output epc_pkg::epc_take_s event_take_o,
   output logic push_state_o,
   output logic core_reset_o,
   output logic emu_mode_o,
   output logic [ADDR_W-1:0] ret_addr_o,
   // Status
   output logic [15:0] core_latch_o,
   output logic [15:0] core_pending_o,
   output logic [NUM_SRC-1:0] source_status_o
);

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   if (NUM_SRC < 2 || NUM_SRC > 64 || ADDR_W < 1) begin : g_chk
      $error("epc: NUM_SRC must be 2..64 and ADDR_W at least 1");
   end

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic epc_pkg::epc_hit_s lowest_set(input logic [15:0] v);
      epc_pkg::epc_hit_s h;
      h = '0;
      for (int i = `EPC_NUM_EVT - 1; i >= 0; i--) begin
         if (v[i]) begin
            h.found = 1'b1;
            h.idx = 4'(i);
         end
      end
      return h;
   endfunction

   // Level offset from level 7 that each source drives after reset.
   function automatic logic [3:0] default_level(input int src);
      logic [3:0] l;
      l = 4'h0;
      if (src >= 14 && src <= 15) l = 4'h1;
      if (src >= 16 && src <= 19) l = 4'h2;
      if ((src >= 20 && src <= 25) || src >= 51) l = 4'h3;
      if (src >= 26 && src <= 31) l = 4'h4;
      if (src >= 32 && src <= 41) l = 4'h5;
      if (src >= 42 && src <= 46) l = 4'h6;
      return l;
   endfunction

   // ---------------------------------------------------------------
   // Input synchronisers and source status
   // ---------------------------------------------------------------
   logic [NUM_SRC-1:0] src_meta_reg;
   logic [NUM_SRC-1:0] src_sync_reg;
   logic nmi_meta_reg;
   logic nmi_sync_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_meta_reg <= '0;
         src_sync_reg <= '0;
         nmi_meta_reg <= 1'b1;
         nmi_sync_reg <= 1'b1;
      end else begin
         src_meta_reg <= periph_req_i;
         src_sync_reg <= src_meta_reg;
         nmi_meta_reg <= nmi_n_i;
         nmi_sync_reg <= nmi_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // System stage: assignment table and routing
   // ---------------------------------------------------------------
   logic [3:0] map_reg [NUM_SRC];
   logic [3:0] map_next [NUM_SRC];
   logic [`EPC_NUM_GP-1:0] gp_in;

   always_comb begin
      map_next = map_reg;
      if (asg_wr_i && int'(asg_src_i) < NUM_SRC && asg_level_i <= `EPC_GP_MAX) begin
         map_next[asg_src_i] = asg_level_i;
      end
      gp_in = '0;
      for (int s = 0; s < NUM_SRC; s++) begin
         for (int g = 0; g < `EPC_NUM_GP; g++) begin
            if (src_sync_reg[s] && map_reg[s] == 4'(g)) begin
               gp_in[g] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int s = 0; s < NUM_SRC; s++) begin
            map_reg[s] <= default_level(s);
         end
      end else begin
         map_reg <= map_next;
      end
   end

   // ---------------------------------------------------------------
   // Core stage: edge detection, latch and pending
   // ---------------------------------------------------------------
   logic [`EPC_NUM_GP-1:0] gp_prev_reg;
   logic [6:0] ded_prev_reg;
   logic nmi_prev_reg;
   logic [6:0] ded_in;
   logic [15:0] set_vec;
   logic [15:0] eligible;
   logic [15:0] latch_reg;
   logic [15:0] latch_next;
   logic [15:0] pending_reg;
   logic [15:0] pending_next;
   logic [15:0] take_vec;
   logic [15:0] rfe_vec;
   epc_pkg::epc_hit_s cand;
   epc_pkg::epc_hit_s top;
   epc_pkg::epc_take_s take_next;
   logic emu_next;
   logic [ADDR_W-1:0] ret_reg [`EPC_NUM_EVT];

   assign ded_in = {core_timer_i, hw_error_i, 1'b0, exception_i,
                    watchdog_nmi_i, reset_req_i, emu_req_i};

   always_comb begin
      set_vec = `EPC_ZERO16;
      // Dedicated events are pulses or levels of core logic; their rise is caught.
      set_vec[`EPC_EV_EMU] = ded_in[0] & ~ded_prev_reg[0];
      set_vec[`EPC_EV_RST] = ded_in[1] & ~ded_prev_reg[1];
      set_vec[`EPC_EV_NMI] = (ded_in[2] & ~ded_prev_reg[2])
                           | (~nmi_sync_reg & nmi_prev_reg);
      set_vec[`EPC_EV_EXC] = ded_in[3] & ~ded_prev_reg[3];
      set_vec[`EPC_EV_HWE] = ded_in[5] & ~ded_prev_reg[5];
      set_vec[`EPC_EV_TMR] = ded_in[6] & ~ded_prev_reg[6];
      set_vec[15:7] = gp_in & ~gp_prev_reg;
      if (sw_raise_i && sw_level_i >= `EPC_GP_BASE) begin
         set_vec[sw_level_i] = 1'b1;
      end

      eligible = latch_reg & ~`EPC_RSVD_BITS
               & (`EPC_NOMASK_BITS | (core_mask_i
               & (gp_enable_i ? ~`EPC_ZERO16 : ~`EPC_GP_BITS)));
      cand = lowest_set(eligible);
      top = lowest_set(pending_reg);

      take_next = '0;
      take_vec = `EPC_ZERO16;
      if (cand.found && (!top.found || cand.idx < top.idx)) begin
         take_next.valid = 1'b1;
         take_next.num = cand.idx;
         take_vec = `EPC_ONE16 << cand.idx;
      end

      rfe_vec = rfe_i ? (`EPC_ONE16 << rfe_num_i) : `EPC_ZERO16;
      // A new edge in the cycle of acceptance is queued, not lost.
      latch_next = (latch_reg & ~take_vec) | set_vec;
      pending_next = (pending_reg & ~rfe_vec) | take_vec;
      if (take_next.valid && take_next.num == `EPC_EV_RST) begin
         pending_next = `EPC_RST_ONLY;
      end

      emu_next = emu_mode_o;
      if (rfe_i && rfe_num_i == `EPC_EV_EMU) emu_next = 1'b0;
      if (take_next.valid && take_next.num == `EPC_EV_EMU) emu_next = 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gp_prev_reg <= '0;
         ded_prev_reg <= '0;
         nmi_prev_reg <= 1'b1;
         latch_reg <= `EPC_ZERO16;
         pending_reg <= `EPC_ZERO16;
         event_take_o <= '0;
         push_state_o <= 1'b0;
         core_reset_o <= 1'b0;
         emu_mode_o <= 1'b0;
         ret_addr_o <= '0;
         source_status_o <= '0;
         for (int i = 0; i < `EPC_NUM_EVT; i++) begin
            ret_reg[i] <= '0;
         end
      end else begin
         gp_prev_reg <= gp_in;
         ded_prev_reg <= ded_in;
         nmi_prev_reg <= nmi_sync_reg;
         latch_reg <= latch_next;
         pending_reg <= pending_next;
         event_take_o <= take_next;
         push_state_o <= take_next.valid;
         core_reset_o <= take_next.valid && take_next.num == `EPC_EV_RST;
         emu_mode_o <= emu_next;
         source_status_o <= src_sync_reg;
         if (take_next.valid) begin
            ret_reg[take_next.num] <= pc_i;
         end
         if (rfe_i) begin
            ret_addr_o <= ret_reg[rfe_num_i];
         end
      end
   end

   assign core_latch_o = latch_reg;
   assign core_pending_o = pending_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_latch_on_edge: assert property (
      ##1 ((latch_reg & $past(set_vec)) == $past(set_vec)))
      else $error("edge did not set its latch bit");
   a_take_highest: assert property (
      event_take_o.valid |->
      ($past(eligible) & ((`EPC_ONE16 << event_take_o.num) - `EPC_ONE16)) == `EPC_ZERO16)
      else $error("granted event was not the highest eligible");
   a_preempt_strict: assert property (
      event_take_o.valid && event_take_o.num != `EPC_EV_RST |->
      ($past(pending_reg) & ((`EPC_ONE16 << event_take_o.num) << 1) - `EPC_ONE16)
      == `EPC_ZERO16)
      else $error("preempted an equal or higher active event");
   a_mask_gate: assert property (
      event_take_o.valid && event_take_o.num >= `EPC_EV_HWE |->
      ($past(core_mask_i) & (`EPC_ONE16 << event_take_o.num)) != `EPC_ZERO16)
      else $error("masked event was serviced");
   a_take_pending: assert property (
      event_take_o.valid |-> core_pending_o[event_take_o.num]
      && ($past(latch_reg) & (`EPC_ONE16 << event_take_o.num)) != `EPC_ZERO16)
      else $error("take without pending or without prior latch");
   a_gp_latency: assert property (
      set_vec[7] && !latch_reg[7] && !pending_reg[7] |=> !pending_reg[7])
      else $error("pending rose too soon after an edge");
   a_reset_pulse: assert property (
      core_reset_o |-> event_take_o.num == `EPC_EV_RST && core_pending_o == `EPC_RST_ONLY)
      else $error("reset pulse without reset event");
   a_emu_enter: assert property (
      event_take_o.valid && event_take_o.num == `EPC_EV_EMU |-> emu_mode_o)
      else $error("emulation event did not enter emulation mode");
   a_state_push: assert property (
      event_take_o.valid |-> push_state_o ##1 !push_state_o || event_take_o.valid)
      else $error("state save missing on event");
   a_ret_addr: assert property (
      event_take_o.valid ##1 (rfe_i && rfe_num_i == $past(event_take_o.num)
      && !event_take_o.valid) |=> ret_addr_o == $past(pc_i, 3))
      else $error("return address does not match saved value");

   c_nested: cover property ($countones(pending_reg) > 1);
   c_preempt: cover property (event_take_o.valid && $past(pending_reg) != `EPC_ZERO16);
   c_reset_take: cover property (core_reset_o);
   c_sw_raise: cover property (sw_raise_i ##[3:6] event_take_o.valid);

endmodule

// >>> tb/epc_pipe_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Pipeline model that returns from the newest event after a delay
// ----------------------------------------------------------------
module epc_pipe_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Bench control
   input wire logic auto_i,
   // Controller side
   input wire epc_pkg::epc_take_s take_i,
   output logic rfe_o,
   output logic [3:0] rfe_num_o
);
   logic [3:0] stk[$];
   int cnt;

   always @(negedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stk.delete();
         cnt = 0;
         rfe_o <= 1'b0;
         rfe_num_o <= 4'h0;
      end else begin
         rfe_o <= 1'b0;
         rfe_num_o <= ~rfe_num_o;
         if (take_i.valid === 1'b1) begin
            stk.push_back(take_i.num);
            // Odd events return at once, so a return can follow its take directly.
            cnt = take_i.num[0] ? 0 : 3;
         end else if (auto_i && stk.size() > 0) begin
            if (cnt > 0) begin
               cnt--;
            end else begin
               rfe_o <= 1'b1;
               rfe_num_o <= stk.pop_back();
               cnt = 3;
            end
         end
      end
   end
endmodule

// >>> tb/epc_event_priority_controller_bench.sv
`timescale 1ns/10ps
module epc_event_priority_controller_bench;
   localparam int NS = 56;
   logic ref_clk_i;
   logic rst_n_i = 1'b0;
   logic [NS-1:0] periph = '0;
   logic nmi_n = 1'b1;
   logic [5:0] ded = 6'h00;
   logic sw_raise = 1'b0;
   logic [3:0] sw_level = 4'h0;
   logic asg_wr = 1'b0;
   logic [5:0] asg_src = 6'h00;
   logic [3:0] asg_level = 4'h0;
   logic [15:0] mask = 16'hffff;
   logic gpen = 1'b1;
   logic [31:0] pc = 32'h0;
   logic autor = 1'b1;
   logic rfe;
   logic [3:0] rfe_num;
   epc_pkg::epc_take_s take;
   logic push, core_reset, emu_mode;
   logic [31:0] ret_addr;
   logic [15:0] latch, pending;
   logic [NS-1:0] status;
   logic [4:0] got;
   logic [3:0] lvl;
   int n, src, seed, errors, comparisons;

   epc_event_priority_controller #(.NUM_SRC(NS), .ADDR_W(32)) dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .periph_req_i(periph), .nmi_n_i(nmi_n),
      .emu_req_i(ded[0]), .reset_req_i(ded[1]), .watchdog_nmi_i(ded[2]),
      .exception_i(ded[3]), .hw_error_i(ded[4]), .core_timer_i(ded[5]),
      .sw_raise_i(sw_raise), .sw_level_i(sw_level), .asg_wr_i(asg_wr),
      .asg_src_i(asg_src), .asg_level_i(asg_level), .core_mask_i(mask),
      .gp_enable_i(gpen), .pc_i(pc), .rfe_i(rfe), .rfe_num_i(rfe_num),
      .event_take_o(take), .push_state_o(push), .core_reset_o(core_reset),
      .emu_mode_o(emu_mode), .ret_addr_o(ret_addr), .core_latch_o(latch),
      .core_pending_o(pending), .source_status_o(status));

   epc_pipe_model pipe (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .auto_i(autor),
      .take_i(take), .rfe_o(rfe), .rfe_num_o(rfe_num));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] dflt(int s);
      if (s < 14 || (s > 46 && s < 51)) return 4'h0;
      if (s < 16) return 4'h1;
      if (s < 20) return 4'h2;
      if (s < 26 || s > 50) return 4'h3;
      if (s < 32) return 4'h4;
      if (s < 42) return 4'h5;
      return 4'h6;
   endfunction

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(int k);
      repeat (k) @(negedge ref_clk_i);
   endtask

   // Waits for one grant; 5'h10 means none came.
   task automatic grab();
      got = 5'h10;
      for (n = 1; n <= 40; n++) begin
         @(negedge ref_clk_i);
         if (take.valid === 1'b1) begin
            got = {1'b0, take.num};
            return;
         end
      end
   endtask

   task automatic fire(logic [5:0] v);
      ded = v;
      cyc(1);
      ded = 6'h00;
   endtask

   task automatic close_out();
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      #(40 * 6000);
      errors++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 31;
      cyc(5);
      rst_n_i = 1'b1;
      cyc(1);
      pc = $random(seed);
      fire(6'h20);
      grab();
      chk("timer take", {got, n[7:0]}, {5'h06, 8'h01});
      chk("push", push, 1'b1);
      chk("pending", pending, 16'h0040);
      chk("latch", latch, 16'h0000);
      cyc(8);
      chk("ret addr", ret_addr, pc);
      chk("idle", pending, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         fire(6'h01 << i);
         grab();
         chk("dedicated", got, i[4:0]);
         if (i == 1) chk("core reset", core_reset, 1'b1);
         if (i == 0) chk("emu mode", emu_mode, 1'b1);
         cyc(10);
      end
      chk("emu left", emu_mode, 1'b0);
      nmi_n = 1'b0;
      grab();
      chk("nmi pin", got, 5'h02);
      nmi_n = 1'b1;
      cyc(10);
      for (int l = 14; l < 16; l++) begin
         sw_level = l[3:0];
         sw_raise = 1'b1;
         cyc(1);
         sw_raise = 1'b0;
         grab();
         chk("software level", got, l[4:0]);
         cyc(10);
      end
      fire(6'h30);
      grab();
      chk("first of pair", got, 5'h05);
      grab();
      chk("second of pair", got, 5'h06);
      cyc(10);
      autor = 1'b0;
      fire(6'h20);
      grab();
      chk("outer", got, 5'h06);
      fire(6'h20);
      grab();
      chk("equal level held", got, 5'h10);
      fire(6'h10);
      grab();
      chk("inner", got, 5'h05);
      chk("nested", pending, 16'h0060);
      autor = 1'b1;
      grab();
      chk("queued timer", got, 5'h06);
      cyc(10);
      mask = 16'hffbf;
      fire(6'h20);
      grab();
      chk("masked", got, 5'h10);
      chk("held latch", latch, 16'h0040);
      mask = 16'hffff;
      grab();
      chk("unmasked", got, 5'h06);
      cyc(10);
      gpen = 1'b0;
      sw_level = 4'he;
      sw_raise = 1'b1;
      cyc(1);
      sw_raise = 1'b0;
      grab();
      chk("gp disabled", got, 5'h10);
      chk("gp held latch", latch, 16'h4000);
      gpen = 1'b1;
      grab();
      chk("gp enabled", got, 5'h0e);
      cyc(10);
      for (int k = 0; k < 8; k++) begin
         src = $unsigned($random(seed)) % NS;
         lvl = (k < 4) ? dflt(src) : 4'($unsigned($random(seed)) % 9);
         if (k >= 4) begin
            asg_src = src[5:0];
            asg_level = lvl;
            asg_wr = 1'b1;
            cyc(1);
            asg_wr = 1'b0;
         end
         periph[src] = 1'b1;
         grab();
         chk("routed level", got, 5'h07 + lvl);
         chk("edge latency", n >= 3, 1'b1);
         chk("source status", status[src], 1'b1);
         periph[src] = 1'b0;
         cyc(12);
         chk("status cleared", status[src], 1'b0);
      end
      close_out();
   end
endmodule
